/* verilog/capture_dma_pkg.sv */
// Shared constants and carrier types for the video capture DMA client.
package capture_dma_pkg;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DESC   = 8'h04;
  localparam logic [7:0] OFS_BASE   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_FIELD  = 8'h14;
  localparam logic [7:0] OFS_WIDTH  = 8'h18;
  localparam logic [7:0] OFS_FRAMES = 8'h1c;
  // Control bits.
  localparam int unsigned CTRL_ENABLE  = 0;
  localparam int unsigned CTRL_ABORT   = 1;
  localparam int unsigned CTRL_CSC_EN  = 2;
  localparam int unsigned CTRL_CSC_DIR = 3;
  // Descriptor bits.
  localparam int unsigned DESC_WRITE = 0;
  localparam int unsigned DESC_DROP  = 1;
  localparam int unsigned DESC_TILED = 2;
  localparam int unsigned DESC_CONT4 = 3;
  // Status and mask bits.
  localparam int unsigned ST_FRAME    = 0;
  localparam int unsigned ST_OVERFLOW = 1;
  localparam int unsigned ST_ZERO     = 2;
  localparam int unsigned ST_MISMATCH = 3;
  localparam int unsigned ST_W        = 4;
  // Reset values.
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [3:0]  DESC_RST = 4'h0;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;
  // Geometry.
  localparam int unsigned BYTES_PER_PIX = 4;
  localparam int unsigned WORD_SHIFT    = 7;
  localparam logic [7:0]  CHROMA_MID    = 8'h80;
  localparam logic [1:0]  AXI_OKAY      = 2'b00;
  localparam logic [1:0]  AXI_SLVERR    = 2'b10;

  typedef struct packed {
    logic        sof;
    logic        eol;
    logic        eof;
    logic [23:0] data;
  } video_beat_t;

  typedef struct packed {
    logic        field_identifier;
    logic        dropped;
    logic        tiled;
    logic [15:0] frame_num;
    logic [15:0] width_bytes;
    logic [15:0] lines;
  } desc_out_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] burst;
  } line_req_t;
endpackage

/* verilog/video_capture_dma_client.sv */
// Video capture DMA client with colour conversion, descriptors and AXI4-Lite registers.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) Converter in path forces field identifier zero.
// (RL2) Converter does RGB to YUV, YUV to RGB.
// (RL3) Parser field identifier readable apart from descriptors.
// (RL4) Software checks parser on repeated field identifiers.
// (RL5) Abort resets the client inside the engine.
// (RL6) Stall after overflow reset must not hang.
// (RL7) Descriptor registers settle at clean end of frame.
// (RL8) Software drops first frame after reset sequence.
// (RL9) Tiled mode scales width by two or four.
// (RL10) Tiled flag held per frame; zero burst refused.
// (RL11) Zero burst widths detected and flagged.
// (RL12) Software keeps one mode bit per client.
// (RL13) Tiled dropped frames use tiled-space addresses; the code steps line addresses by unscaled line bytes in every mode.
// (RL14) Tiled lines grouped; unequal lengths flagged.
// (RL15) Abort returns both descriptor registers to reset.
module video_capture_dma_client
  import capture_dma_pkg::*;
(
  input  wire logic              sys_clk,        // system clock, 125 MHz
  input  wire logic              arst_n,         // asynchronous reset, active low
  input  wire logic              awvalid,        // write address valid
  output logic                   awready,        // write address ready
  input  wire logic [ADDR_W-1:0] awaddr,         // write address
  input  wire logic              wvalid,         // write data valid
  output logic                   wready,         // write data ready
  input  wire logic [31:0]       wdata,          // write data
  input  wire logic [3:0]        wstrb,          // write byte strobes
  output logic                   bvalid,         // write response valid
  input  wire logic              bready,         // write response ready
  output logic [1:0]             bresp,          // write response
  input  wire logic              arvalid,        // read address valid
  output logic                   arready,        // read address ready
  input  wire logic [ADDR_W-1:0] araddr,         // read address
  output logic                   rvalid,         // read data valid
  input  wire logic              rready,         // read data ready
  output logic [31:0]            rdata,          // read data
  output logic [1:0]             rresp,          // read response
  input  wire logic              vid_valid,      // captured beat valid
  input  wire video_beat_t       vid_beat,       // captured beat
  input  wire logic              parser_field,   // field identifier from sync parser
  output logic                   pix_valid,      // pixel word to memory valid
  input  wire logic              pix_ready,      // memory accepts pixel word
  output logic [31:0]            pix_data,       // pixel word to memory
  output logic                   req_valid,      // line burst request valid
  input  wire logic              req_ready,      // interconnect accepts request
  output line_req_t              req,            // line burst request
  output logic                   desc_valid,     // output descriptor valid
  input  wire logic              desc_ready,     // descriptor accepted
  output desc_out_t              desc,           // output descriptor
  output logic                   irq             // interrupt, active high level
);

  logic [3:0]      ctrl_reg;
  logic [3:0]      desc_cfg_reg;
  logic [31:0]     base_reg;
  logic [ST_W-1:0] status_reg;
  logic [ST_W-1:0] mask_reg;
  logic            parser_field_reg;
  logic [15:0]     width_reg;
  logic [15:0]     frame_cnt_reg;
  logic            abort_reg;
  // The two descriptor-writing registers of the client.
  logic            dw_frame_reg;
  logic            dw_pending_reg;
  logic            in_frame_reg;
  logic            frame_tiled_reg;
  logic            frame_cont4_reg;
  logic            frame_drop_reg;
  logic [15:0]     pix_cnt_reg;
  logic [15:0]     line_cnt_reg;
  logic [15:0]     group_width_reg;
  logic [1:0]      group_idx_reg;
  logic [31:0]     line_addr_reg;
  logic [ST_W-1:0] events;

  // Write channel capture: address and data are taken in either order.
  logic            aw_held_reg;
  logic            w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]     w_data_reg;
  logic [3:0]      w_strb_reg;
  logic            wr_fire;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid      <= 1'b0;
      bresp       <= AXI_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= (aw_addr_reg[7:5] == 3'h0 && aw_addr_reg[1:0] == 2'b00) ?
                       AXI_OKAY : AXI_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  assign awready = !aw_held_reg;
  assign wready  = !w_held_reg;

  logic wr_ctrl;
  logic wr_desc;
  logic wr_base;
  logic wr_status;
  logic wr_mask;
  assign wr_ctrl   = wr_fire && aw_addr_reg == OFS_CTRL && w_strb_reg[0];
  assign wr_desc   = wr_fire && aw_addr_reg == OFS_DESC && w_strb_reg[0];
  assign wr_base   = wr_fire && aw_addr_reg == OFS_BASE;
  assign wr_status = wr_fire && aw_addr_reg == OFS_STATUS && w_strb_reg[0];
  assign wr_mask   = wr_fire && aw_addr_reg == OFS_MASK && w_strb_reg[0];

  // Abort is a one-cycle strobe; the written bit never reads back as set.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg     <= CTRL_RST;
      desc_cfg_reg <= DESC_RST;
      base_reg     <= BASE_RST;
      mask_reg     <= MASK_RST;
      abort_reg    <= 1'b0;
    end
    else
    begin
      abort_reg <= wr_ctrl && w_data_reg[CTRL_ABORT];
      if (wr_ctrl)
        ctrl_reg <= w_data_reg[3:0] & ~(4'h1 << CTRL_ABORT);
      if (wr_desc)
        desc_cfg_reg <= w_data_reg[3:0];
      if (wr_base)
      begin
        for (int i = 0; i < 4; i++)
          if (w_strb_reg[i])
            base_reg[8*i +: 8] <= w_data_reg[8*i +: 8];
      end
      if (wr_mask)
        mask_reg <= w_data_reg[ST_W-1:0];
    end
  end

  // Set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~(wr_status ? w_data_reg[ST_W-1:0] : '0)) | events;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(((status_reg & ~(wr_status ? w_data_reg[ST_W-1:0] : '0)) | events) & mask_reg);
  end

  // Read channel.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= AXI_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= AXI_OKAY;
      unique case (araddr)
        OFS_CTRL:   rdata <= {28'h0, ctrl_reg};
        OFS_DESC:   rdata <= {28'h0, desc_cfg_reg};
        OFS_BASE:   rdata <= base_reg;
        OFS_STATUS: rdata <= {28'h0, status_reg};
        OFS_MASK:   rdata <= {28'h0, mask_reg};
        OFS_FIELD:  rdata <= {31'h0, parser_field_reg}; // RL3
        OFS_WIDTH:  rdata <= {16'h0, width_reg};
        OFS_FRAMES: rdata <= {16'h0, frame_cnt_reg};
        default:
        begin
          rdata <= '0;
          rresp <= AXI_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  assign arready = !rvalid;

  // Crude fixed-point conversion; good enough for capture preview paths.
  function automatic logic [23:0] convert(input logic [23:0] p, input logic to_rgb);
    logic [17:0] y;
    logic [9:0]  u;
    logic [9:0]  v;
    logic [9:0]  r;
    logic [9:0]  b;
    y = 18'd77 * p[23:16] + 18'd150 * p[15:8] + 18'd29 * p[7:0];
    u = {2'b00, CHROMA_MID} + {2'b00, p[7:0] >> 1} - {2'b00, y[16:9]};
    v = {2'b00, CHROMA_MID} + {2'b00, p[23:16] >> 1} - {2'b00, y[16:9]};
    r = {2'b00, p[23:16]} + {1'b0, p[7:0], 1'b0} - {1'b0, CHROMA_MID, 1'b0};
    b = {2'b00, p[23:16]} + {1'b0, p[15:8], 1'b0} - {1'b0, CHROMA_MID, 1'b0};
    if (to_rgb)
      convert = {r[9] ? 8'h00 : (r[8] ? 8'hff : r[7:0]), p[23:16],
                 b[9] ? 8'h00 : (b[8] ? 8'hff : b[7:0])};
    else
      convert = {y[15:8], u[7:0], v[7:0]};
  endfunction

  logic stall;
  logic accept;
  assign stall  = pix_valid && !pix_ready;
  assign accept = vid_valid && ctrl_reg[CTRL_ENABLE] && !abort_reg;

  // Pixel path: one holding word; a beat arriving during a stall inside a kept frame is an overflow.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pix_valid <= 1'b0;
      pix_data  <= '0;
    end
    else if (abort_reg)
      pix_valid <= 1'b0;
    else if (accept && !stall &&
             (vid_beat.sof ? !desc_cfg_reg[DESC_DROP] : in_frame_reg && !frame_drop_reg))
    begin
      pix_valid <= 1'b1;
      pix_data  <= {8'h00, ctrl_reg[CTRL_CSC_EN] ?
                   convert(vid_beat.data, ctrl_reg[CTRL_CSC_DIR]) : vid_beat.data}; // RL2
    end
    else if (pix_ready)
      pix_valid <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      parser_field_reg <= 1'b0;
    else if (vid_valid && vid_beat.sof)
      parser_field_reg <= parser_field; // RL3
  end

  // Per-line width and burst sizing.
  logic [15:0] line_bytes;
  logic [17:0] scaled;
  logic [15:0] burst;
  assign line_bytes = (pix_cnt_reg + 16'd1) * 16'(BYTES_PER_PIX);
  assign scaled     = !frame_tiled_reg ? {2'b00, line_bytes} :
                      (frame_cont4_reg ? {line_bytes, 2'b00} : {1'b0, line_bytes, 1'b0}); // RL9
  assign burst      = !frame_tiled_reg ? 16'(scaled >> WORD_SHIFT) :
                      (frame_cont4_reg ? 16'(scaled >> (WORD_SHIFT + 2)) :
                                         16'(scaled >> (WORD_SHIFT + 1))); // RL10

  logic line_end;
  logic frame_end;
  logic group_last;
  assign line_end   = accept && in_frame_reg && vid_beat.eol;
  assign frame_end  = accept && in_frame_reg && vid_beat.eof;
  assign group_last = frame_cont4_reg ? (group_idx_reg == 2'd3) : (group_idx_reg == 2'd1);

  always_comb
  begin
    events = '0;
    events[ST_FRAME]    = frame_end;
    events[ST_OVERFLOW] = accept && in_frame_reg && stall && !frame_drop_reg;
    events[ST_ZERO]     = line_end && !frame_drop_reg && burst == 16'd0; // RL11
    events[ST_MISMATCH] = line_end && frame_tiled_reg && group_idx_reg != 2'd0 &&
                          line_bytes != group_width_reg; // RL14
  end

  // Frame state. Abort clears the frame flag, the pixel, line and group counters, and both descriptor registers.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_frame_reg    <= 1'b0;
      frame_tiled_reg <= 1'b0;
      frame_cont4_reg <= 1'b0;
      frame_drop_reg  <= 1'b0;
      dw_frame_reg    <= 1'b0;
      dw_pending_reg  <= 1'b0;
      pix_cnt_reg     <= '0;
      line_cnt_reg    <= '0;
      group_width_reg <= '0;
      group_idx_reg   <= '0;
      line_addr_reg   <= '0;
      width_reg       <= '0;
      frame_cnt_reg   <= '0;
    end
    else if (abort_reg)
    begin
      in_frame_reg   <= 1'b0; // RL5
      dw_frame_reg   <= 1'b0; // RL15
      dw_pending_reg <= 1'b0; // RL6
      pix_cnt_reg    <= '0;
      line_cnt_reg   <= '0;
      group_idx_reg  <= '0;
    end
    else if (accept && vid_beat.sof)
    begin
      // Mode bits are sampled here only, so a later descriptor cannot change them mid-frame.
      in_frame_reg    <= 1'b1;
      frame_tiled_reg <= desc_cfg_reg[DESC_TILED]; // RL10
      frame_cont4_reg <= desc_cfg_reg[DESC_CONT4];
      frame_drop_reg  <= desc_cfg_reg[DESC_DROP];
      dw_frame_reg    <= desc_cfg_reg[DESC_WRITE];
      // The start beat is already the first pixel of line zero.
      pix_cnt_reg     <= 16'd1;
      line_cnt_reg    <= '0;
      group_idx_reg   <= '0;
      line_addr_reg   <= base_reg;
    end
    else if (accept && in_frame_reg)
    begin
      pix_cnt_reg <= line_end ? 16'd0 : pix_cnt_reg + 16'd1;
      if (line_end)
      begin
        width_reg     <= line_bytes;
        line_cnt_reg  <= line_cnt_reg + 16'd1;
        line_addr_reg <= line_addr_reg + {16'h0, line_bytes};
        if (group_idx_reg == 2'd0)
          group_width_reg <= line_bytes; // RL14
        group_idx_reg <= (!frame_tiled_reg || group_last) ? 2'd0 : group_idx_reg + 2'd1;
      end
      if (frame_end)
      begin
        in_frame_reg   <= 1'b0;
        frame_cnt_reg  <= frame_cnt_reg + 16'd1;
        dw_pending_reg <= dw_frame_reg; // RL7
        dw_frame_reg   <= 1'b0;
      end
    end
    else if (desc_valid && desc_ready)
      dw_pending_reg <= 1'b0;
  end

  // Line burst request, issued at each line end unless dropped, zero-sized or the previous request is still waiting.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_valid <= 1'b0;
      req       <= '0;
    end
    else if (abort_reg)
      req_valid <= 1'b0;
    else if (line_end && !frame_drop_reg && burst != 16'd0 && !(req_valid && !req_ready))
    begin
      req_valid  <= 1'b1; // RL10
      req.addr   <= line_addr_reg;
      req.burst  <= burst;
    end
    else if (req_ready)
      req_valid <= 1'b0;
  end

  // Output descriptor after a frame whose descriptor-write bit was set.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      desc_valid <= 1'b0;
      desc       <= '0;
    end
    else if (abort_reg)
      desc_valid <= 1'b0;
    else if (frame_end && dw_frame_reg)
    begin
      desc_valid            <= 1'b1;
      desc.field_identifier <= ctrl_reg[CTRL_CSC_EN] ? 1'b0 : parser_field_reg; // RL1
      desc.dropped          <= frame_drop_reg;
      desc.tiled            <= frame_tiled_reg;
      desc.frame_num        <= frame_cnt_reg;
      // The end beat also closes the last line, whose counts land on this same edge.
      desc.width_bytes      <= line_bytes;
      desc.lines            <= line_cnt_reg + 16'd1;
    end
    else if (desc_ready)
      desc_valid <= 1'b0;
  end

endmodule

/* dv/mem_sink_model.sv */
// Memory side model: takes pixel words, line requests and descriptors at a set pace.
`timescale 1ns/1ps
module mem_sink_model
(
  input  wire logic       sys_clk,    // clock
  input  wire logic       arst_n,     // reset, active low
  input  wire logic [1:0] pace,       // 0 prompt, 1 slow, 2 stalled
  output logic            pix_ready,  // pixel word taken
  output logic            req_ready,  // line request taken
  output logic            desc_ready  // descriptor taken
);
  logic [1:0] tick;
  logic       go;
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      tick <= 2'h0;
    else
      tick <= tick + 2'h1;
  // Slow pace opens one cycle in four, so a transfer waits unless it is offered in that open cycle.
  assign go = (pace == 2'h0) || (pace == 2'h1 && tick == 2'h0);
  assign pix_ready = go;
  assign req_ready = go;
  assign desc_ready = go;
endmodule

/* dv/video_capture_dma_client_checker.sv */
// Port assertions for the video capture DMA client.
`timescale 1ns/1ps
module capture_checker
  import capture_dma_pkg::*;
(
  input wire logic        sys_clk,     // clock
  input wire logic        arst_n,      // reset, active low
  input wire logic        arvalid,     // read address valid
  input wire logic        arready,     // read address ready
  input wire logic        rvalid,      // read data valid
  input wire logic        rready,      // read data ready
  input wire logic [31:0] rdata,       // read data
  input wire logic        pix_valid,   // pixel valid
  input wire logic        pix_ready,   // pixel ready
  input wire logic [31:0] pix_data,    // pixel word
  input wire logic        req_valid,   // request valid
  input wire logic        req_ready,   // request ready
  input wire line_req_t   req,         // line request
  input wire logic        desc_valid,  // descriptor valid
  input wire logic        desc_ready,  // descriptor ready
  input wire desc_out_t   desc         // descriptor
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
  a_pix_hold: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
    else $error("pixel word dropped early");
  a_pix_low: assert property (pix_valid |-> pix_data[31:24] == 8'h00)
    else $error("pixel word upper byte set");
  a_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req))
    else $error("line request dropped early");
  a_burst_nonzero: assert property (req_valid |-> req.burst != 16'h0000)
    else $error("zero burst issued");
  a_desc_hold: assert property (desc_valid && !desc_ready |=> desc_valid && $stable(desc))
    else $error("descriptor dropped early");
  c_desc: cover property (desc_valid && desc_ready);
  c_req: cover property (req_valid && req_ready);
  c_pix_stall: cover property (pix_valid && !pix_ready);
  c_read: cover property (rvalid && rready);
endmodule
bind video_capture_dma_client capture_checker capture_checker_i (.sys_clk, .arst_n, .arvalid,
  .arready, .rvalid, .rready, .rdata, .pix_valid, .pix_ready, .pix_data, .req_valid,
  .req_ready, .req, .desc_valid, .desc_ready, .desc);

/* dv/tb_video_capture_dma_client.sv */
// Self-checking bench for the video capture DMA client.
`timescale 1ns/1ps
module tb_video_capture_dma_client;
  import capture_dma_pkg::*;
  logic        sys_clk = 1'b0, arst_n = 1'b0, quiet = 1'b0, lf = 1'b0, raw = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h9662, base_v = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  pace = 2'h0;
  logic        vid_valid = 1'b0, parser_field = 1'b0;
  video_beat_t vid_beat = '0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        pix_valid, pix_ready, req_valid, req_ready, desc_valid, desc_ready;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, pix_data;
  line_req_t   req;
  desc_out_t   desc;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [47:0] exp_q[$];
  logic [50:0] exp_d[$];
  logic [23:0] exp_p[$];
  int          n_fail = 0, samples_checked = 0, nfr = 0;
  always #4 sys_clk = ~sys_clk;
  video_capture_dma_client video_capture_dma_client_i (.sys_clk, .arst_n, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .vid_valid, .vid_beat, .parser_field,
    .pix_valid, .pix_ready, .pix_data, .req_valid, .req_ready, .req, .desc_valid,
    .desc_ready, .desc, .irq);
  mem_sink_model mem_sink_model_i (.sys_clk, .arst_n, .pace, .pix_ready, .req_ready,
    .desc_ready);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] burst_of(input int b, input logic [3:0] d);
    int f;
    f = d[DESC_CONT4] ? 4 : 2;
    return d[DESC_TILED] ? 16'(((b * f) >> WORD_SHIFT) / f) : 16'(b >> WORD_SHIFT);
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    exp_b.push_back(e);
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge sys_clk);
      ad = ad | awready;
      wd = wd | wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    while (!bvalid) @(posedge sys_clk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge sys_clk);
    rready <= 1'b0;
  endtask
  // One beat every five cycles keeps pace with the slow memory side.
  task automatic frame(input int px, input int lpx, input int ln, input logic [3:0] d,
                       input logic inline_colour_converter);
    int w;
    logic [31:0] a;
    lf = seed[0];
    a = base_v;
    raw = !inline_colour_converter;
    parser_field <= lf;
    if (d[DESC_WRITE])
      exp_d.push_back({inline_colour_converter ? 1'b0 : lf, d[DESC_DROP], d[DESC_TILED], 16'(nfr),
                       16'(lpx * BYTES_PER_PIX), 16'(ln)});
    nfr++;
    for (int l = 0; l < ln; l++)
    begin
      w = (l == ln - 1) ? lpx : px;
      if (!d[DESC_DROP] && !quiet && burst_of(w * BYTES_PER_PIX, d) != 16'h0)
        exp_q.push_back({a, burst_of(w * BYTES_PER_PIX, d)});
      a = a + 32'(w * BYTES_PER_PIX);
      for (int p = 0; p < w; p++)
      begin
        @(posedge sys_clk);
        vid_valid <= 1'b1;
        vid_beat <= '{l == 0 && p == 0, p == w - 1, l == ln - 1 && p == w - 1, seed[23:0]};
        if (!d[DESC_DROP] && !quiet && !inline_colour_converter)
          exp_p.push_back(seed[23:0]);
        seed = xs(seed);
        @(posedge sys_clk);
        vid_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
      end
    end
    repeat (30) @(posedge sys_clk);
  endtask
  task automatic abort_to(input logic [3:0] d);
    axw(OFS_CTRL, 32'h3, AXI_OKAY);
    axw(OFS_DESC, {28'h0, d}, AXI_OKAY);
  endtask
  always @(posedge sys_clk)
  begin
    if (bvalid && bready)
      check(bresp, exp_b.pop_front());
    if (rvalid && rready)
      check({rresp, rdata}, exp_r.pop_front());
    if (req_valid && req_ready && !quiet)
      check(req, exp_q.pop_front());
    if (pix_valid && pix_ready && !quiet && raw)
      check(pix_data, {8'h00, exp_p.pop_front()});
    if (desc_valid && desc_ready)
      check(desc, exp_d.pop_front());
  end
  initial
  begin
    #(300000);
    n_fail++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    axr(OFS_CTRL, {AXI_OKAY, 28'h0, CTRL_RST});
    axr(OFS_DESC, {AXI_OKAY, 28'h0, DESC_RST});
    axr(OFS_BASE, {AXI_OKAY, BASE_RST});
    axr(OFS_MASK, {AXI_OKAY, 28'h0, MASK_RST});
    axr(8'h20, {AXI_SLVERR, 32'h0});
    axw(8'h22, 32'h1, AXI_SLVERR);
    axw(OFS_BASE, seed, AXI_OKAY);
    base_v = seed;
    axr(OFS_BASE, {AXI_OKAY, seed});
    axw(OFS_CTRL, 32'h1, AXI_OKAY);
    axw(OFS_DESC, 32'h1, AXI_OKAY);
    frame(64, 64, 4, 4'h1, 1'b0);
    check(irq, 1'b0);
    axw(OFS_MASK, 32'h1, AXI_OKAY);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b1);
    axw(OFS_STATUS, 32'hf, AXI_OKAY);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b0);
    axr(OFS_FIELD, {AXI_OKAY, 31'h0, lf});
    axr(OFS_FRAMES, {AXI_OKAY, 32'h1});
    for (int c = 0; c < 2; c++)
    begin
      axw(OFS_CTRL, 32'h5 | (c << CTRL_CSC_DIR), AXI_OKAY);
      frame(32, 32, 2, 4'h1, 1'b1);
      axr(OFS_FIELD, {AXI_OKAY, 31'h0, lf});
    end
    axw(OFS_CTRL, 32'h1, AXI_OKAY);
    axw(OFS_STATUS, 32'hf, AXI_OKAY);
    frame(16, 16, 2, 4'h1, 1'b0);
    axr(OFS_STATUS, {AXI_OKAY, 32'h5});
    axw(OFS_STATUS, 32'hf, AXI_OKAY);
    axw(OFS_DESC, 32'h3, AXI_OKAY);
    frame(32, 32, 2, 4'h3, 1'b0);
    abort_to(4'h5);
    frame(48, 48, 4, 4'h5, 1'b0);
    axw(OFS_DESC, 32'hd, AXI_OKAY);
    frame(48, 48, 4, 4'hd, 1'b0);
    axw(OFS_DESC, 32'h7, AXI_OKAY);
    frame(48, 48, 2, 4'h7, 1'b0);
    axw(OFS_DESC, 32'h4, AXI_OKAY);
    axw(OFS_STATUS, 32'hf, AXI_OKAY);
    quiet = 1'b1;
    frame(48, 40, 4, 4'h4, 1'b0);
    axr(OFS_STATUS, {AXI_OKAY, 32'h9});
    abort_to(4'h1);
    axw(OFS_STATUS, 32'hf, AXI_OKAY);
    pace <= 2'h2;
    frame(16, 16, 2, 4'h1, 1'b0);
    axr(OFS_STATUS, {AXI_OKAY, 32'h7});
    pace <= 2'h0;
    repeat (10) @(posedge sys_clk);
    axw(OFS_CTRL, 32'h3, AXI_OKAY);
    quiet <= 1'b0;
    axr(OFS_DESC, {AXI_OKAY, 32'h1});
    axr(OFS_CTRL, {AXI_OKAY, 32'h1});
    pace <= 2'h1;
    axw(OFS_DESC, 32'h3, AXI_OKAY);
    frame(32, 32, 2, 4'h3, 1'b0);
    axw(OFS_DESC, 32'h1, AXI_OKAY);
    frame(64, 64, 2, 4'h1, 1'b0);
    repeat (50) @(posedge sys_clk);
    check(exp_d.size(), 0);
    check(exp_q.size(), 0);
    check(exp_p.size(), 0);
    wrap_up();
  end
endmodule
